// >>> rtl/aiag_pkg.sv
// constants, operand codes and carrier types for the indirect-offset address generator
// assumes a single 20 MHz cpu clock and a decoder that presents one operand per cycle
// What this block does
// [RULE1] operands act only while pointer mode select is cleared (dsp mode)
// [RULE2] bit-reversed post-add issues old pointer, then adds the RULE3 offset, sign-extended 16-bit only with compatibility bit 0
// [RULE3] compatibility bit picks offset: 0 temp register zero, 1 extended pointer zero
// [RULE4] bit-reversed add propagates carries from msb toward lsb
// [RULE5] bit-reversed post-subtract issues old pointer, then reverse-borrow subtract
// [RULE6] circular pointer under bit-reverse: address adds buffer base, pointer unchanged
// [RULE7] post-add by temp one issues old pointer, then adds sign-extended temp one
// [RULE8] post-subtract by temp one issues old pointer, then subtracts temp one
// [RULE9] indexed by temp one: address is pointer plus temp one, no update
// [RULE10] immediate indexed: address is pointer plus sign-extended immediate, no update
// [RULE11] immediate operand comes in two-byte extension, never issued in parallel
// [RULE12] i/o space allowed for all operands except the immediate-offset one
// [RULE13] normal add and subtract wrap modulo 2^23, written back same instruction
package aiag_pkg;
   localparam int AW = 23;
   localparam int OW = 16;
   localparam int NPTR = 8;
   localparam int PW = 3;
   localparam logic MODE_DSP = 1'h0;
   localparam logic CM_TEMP0 = 1'h0;
   localparam int EXT_BYTES = 2;

   typedef enum logic [2:0] {
      AIAG_OP_BR_ADD = 3'h0,
      AIAG_OP_BR_SUB = 3'h1,
      AIAG_OP_T1_ADD = 3'h2,
      AIAG_OP_T1_SUB = 3'h3,
      AIAG_OP_T1_IDX = 3'h4,
      AIAG_OP_K16_IDX = 3'h5
   } aiag_op_t;

   typedef enum logic [1:0] {
      AIAG_SP_DATA = 2'h0,
      AIAG_SP_MMR = 2'h1,
      AIAG_SP_BIT = 2'h2,
      AIAG_SP_IO = 2'h3
   } aiag_space_t;

   // one decoded operand from the instruction decoder
   typedef struct packed {
      logic valid;
      aiag_op_t op;
      logic [PW-1:0] ptr;
      aiag_space_t space;
      logic parallel;
      logic [OW-1:0] imm;
   } aiag_req_t;

   // one issued address toward the access buses
   typedef struct packed {
      logic valid;
      aiag_space_t space;
      logic [AW-1:0] addr;
   } aiag_acc_t;
endpackage

// >>> rtl/aiag_sext.sv
// sign extender from the 16-bit offset width to the address width
// assumes out width is not below in width
`timescale 1ns/1ps
`default_nettype none
module aiag_sext #(
   parameter int IW = aiag_pkg::OW,
   parameter int XW = aiag_pkg::AW
) (
   input wire logic [IW-1:0] din,
   output logic [XW-1:0] dout
);
   initial begin
      if (XW < IW) $error("extender narrower than input");
   end
   // replicate the sign bit into the upper field
   assign dout = {{(XW-IW){din[IW-1]}}, din};
endmodule
`default_nettype wire

// >>> rtl/aiag_revadd.sv
// reverse-carry adder: carries run from the msb toward the lsb
// assumes purely combinational use inside the address generator
`timescale 1ns/1ps
`default_nettype none
module aiag_revadd #(
   parameter int W = aiag_pkg::AW
) (
   input wire logic [W-1:0] a,
   input wire logic [W-1:0] b,
   input wire logic sub,
   output logic [W-1:0] sum
);
   logic [W:0] c;
   logic [W-1:0] bx;
   // subtract as add of the complement, the +1 injected at the msb end
   assign bx = sub ? ~b : b;
   assign c[W] = sub;
   genvar i;
   generate
      for (i = W-1; i >= 0; i = i - 1) begin : g_bit
         assign sum[i] = a[i] ^ bx[i] ^ c[i+1]; // [RULE4]
         assign c[i] = (a[i] & bx[i]) | (a[i] & c[i+1]) | (bx[i] & c[i+1]); // [RULE4]
      end
   endgenerate
endmodule
`default_nettype wire

// >>> rtl/aiag_top.sv
// indirect-offset address generator: pointer file, offsets and issued address
// assumes decoder inputs synchronous to REF_CLK; pointer loads come from the cpu register path
`timescale 1ns/1ps
`default_nettype none
module aiag_top #(
   parameter int NP = aiag_pkg::NPTR
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire aiag_pkg::aiag_req_t REQ,
   input wire logic POINTER_MODE_SELECT,
   input wire logic COMPATIBILITY_MODE_BIT,
   input wire logic [aiag_pkg::OW-1:0] TEMP_REGISTER_ZERO,
   input wire logic [aiag_pkg::OW-1:0] TEMP_REGISTER_ONE,
   input wire logic [NP-1:0] CIRC_ENABLE,
   input wire logic [NP*aiag_pkg::OW-1:0] BUFFER_START_BASE,
   input wire logic PTR_LOAD,
   input wire logic [aiag_pkg::PW-1:0] PTR_LOAD_SEL,
   input wire logic [aiag_pkg::AW-1:0] PTR_LOAD_VAL,
   output aiag_pkg::aiag_acc_t ACC,
   output logic REQ_REJECT,
   output logic [NP*aiag_pkg::AW-1:0] EXTENDED_AUX_POINTER_N
);
   localparam int AW = aiag_pkg::AW;
   localparam int OW = aiag_pkg::OW;

   initial begin
      if (NP != (1 << aiag_pkg::PW)) $error("pointer count must match index width");
   end

   logic [AW-1:0] ptr_r [NP];
   logic [AW-1:0] cur;
   logic [OW-1:0] br_off16;
   logic [OW-1:0] off16;
   logic [AW-1:0] off_x;
   logic [AW-1:0] imm_x;
   logic [AW-1:0] base_x;
   logic [AW-1:0] rev_sum;
   logic [AW-1:0] upd_nxt;
   logic [AW-1:0] addr_nxt;
   logic is_br;
   logic is_sub;
   logic circ;
   logic upd;
   logic legal;
   aiag_pkg::aiag_acc_t acc_r;

   assign cur = ptr_r[REQ.ptr];
   assign is_br = (REQ.op == aiag_pkg::AIAG_OP_BR_ADD) || (REQ.op == aiag_pkg::AIAG_OP_BR_SUB);
   assign is_sub = (REQ.op == aiag_pkg::AIAG_OP_BR_SUB) || (REQ.op == aiag_pkg::AIAG_OP_T1_SUB);
   assign circ = CIRC_ENABLE[REQ.ptr];

   // bit-reverse offset: temp zero, or the low word of pointer zero
   assign br_off16 = (COMPATIBILITY_MODE_BIT == aiag_pkg::CM_TEMP0) ? TEMP_REGISTER_ZERO
                     : ptr_r[0][OW-1:0]; // [RULE3]
   assign off16 = is_br ? br_off16 : TEMP_REGISTER_ONE;

   aiag_sext u_sext_off (
      .din(off16),
      .dout(off_x)
   );

   aiag_sext u_sext_imm (
      .din(REQ.imm),
      .dout(imm_x)
   );

   aiag_sext u_sext_base (
      .din(BUFFER_START_BASE[REQ.ptr*OW +: OW]),
      .dout(base_x)
   );

   // extended pointer zero is used whole in compat mode, not the sign-extended word
   aiag_revadd u_rev (
      .a(cur),
      .b((COMPATIBILITY_MODE_BIT == aiag_pkg::CM_TEMP0) ? off_x : ptr_r[0]),
      .sub(REQ.op == aiag_pkg::AIAG_OP_BR_SUB),
      .sum(rev_sum)
   );

   // reject dsp-mode-only operands in control mode, parallel immediates and immediate i/o
   always_comb begin
      legal = (POINTER_MODE_SELECT == aiag_pkg::MODE_DSP); // [RULE1]
      if (REQ.op == aiag_pkg::AIAG_OP_K16_IDX) begin
         if (REQ.parallel) legal = 1'b0; // [RULE11]
         if (REQ.space == aiag_pkg::AIAG_SP_IO) legal = 1'b0; // [RULE12]
      end
      if (REQ.op > aiag_pkg::AIAG_OP_K16_IDX) legal = 1'b0;
   end

   assign REQ_REJECT = REQ.valid && !legal;

   // address and next pointer value for each operand
   always_comb begin
      addr_nxt = cur;
      upd_nxt = cur;
      upd = 1'b0;
      unique case (REQ.op)
         aiag_pkg::AIAG_OP_BR_ADD, aiag_pkg::AIAG_OP_BR_SUB: begin
            if (circ) begin
               addr_nxt = AW'(cur + base_x); // [RULE6]
            end else begin
               upd_nxt = rev_sum; // [RULE2] [RULE5]
               upd = 1'b1;
            end
         end
         aiag_pkg::AIAG_OP_T1_ADD: begin
            upd_nxt = AW'(cur + off_x); // [RULE7] [RULE13]
            upd = 1'b1;
         end
         aiag_pkg::AIAG_OP_T1_SUB: begin
            upd_nxt = AW'(cur - off_x); // [RULE8] [RULE13]
            upd = 1'b1;
         end
         aiag_pkg::AIAG_OP_T1_IDX: begin
            addr_nxt = AW'(cur + off_x); // [RULE9]
         end
         aiag_pkg::AIAG_OP_K16_IDX: begin
            addr_nxt = AW'(cur + imm_x); // [RULE10]
         end
         default: begin
            addr_nxt = cur;
         end
      endcase
   end

   // pointer file: post-modify written back in the same cycle the old value is issued
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         for (int k = 0; k < NP; k++) ptr_r[k] <= '0;
      end else if (REQ.valid && legal && upd) begin
         ptr_r[REQ.ptr] <= upd_nxt; // [RULE13]
      end else if (PTR_LOAD) begin
         ptr_r[PTR_LOAD_SEL] <= PTR_LOAD_VAL;
      end
   end

   // issued address registered so the buses see a clean value
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         acc_r <= '0;
      end else begin
         acc_r.valid <= REQ.valid && legal;
         acc_r.space <= REQ.space; // [RULE12]
         acc_r.addr <= addr_nxt;
      end
   end

   assign ACC = acc_r;

   // flattened pointer view for the rest of the cpu
   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_out
         assign EXTENDED_AUX_POINTER_N[g*AW +: AW] = ptr_r[g];
      end
   endgenerate
endmodule
`default_nettype wire

// >>> dv/aiag_dec_model.sv
// decoder model: packs one decoded operand for the generator
// assumes fields change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module aiag_dec_model (
   input wire logic v,
   input wire logic [2:0] op,
   input wire logic [1:0] sp,
   input wire logic par,
   input wire logic [15:0] ext,
   output aiag_pkg::aiag_req_t req
);
   // constant only from the two-byte extension; parallel only when a test orders it
   assign req = '{v, aiag_pkg::aiag_op_t'(op), 3'h3, aiag_pkg::aiag_space_t'(sp), par, ext};
endmodule
`default_nettype wire

// >>> dv/aiag_top_checker.sv
// checker: refusals, issue timing, offset arithmetic
// assumes a bind to aiag_top, ports only
`timescale 1ns/1ps
`default_nettype none
module aiag_top_checker #(
   parameter int NP = 8
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire aiag_pkg::aiag_req_t REQ,
   input wire logic POINTER_MODE_SELECT,
   input wire logic [15:0] TEMP_REGISTER_ONE,
   input wire logic PTR_LOAD,
   input wire aiag_pkg::aiag_acc_t ACC,
   input wire logic REQ_REJECT,
   input wire logic [NP*23-1:0] EXTENDED_AUX_POINTER_N
);
   logic [22:0] p_r, t_r, k_r, nw;
   logic [2:0] i_r;
   logic ok;
   assign ok = REQ.valid && !REQ_REJECT && !PTR_LOAD;
   assign nw = EXTENDED_AUX_POINTER_N[i_r*23+:23];
   // snapshot of the operand, since the pointer moves at the issuing edge
   always_ff @(posedge REF_CLK) begin
      p_r <= EXTENDED_AUX_POINTER_N[REQ.ptr*23+:23];
      t_r <= {{7{TEMP_REGISTER_ONE[15]}}, TEMP_REGISTER_ONE};
      k_r <= {{7{REQ.imm[15]}}, REQ.imm};
      i_r <= REQ.ptr;
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);
   chk_mode_refuse: assert property (REQ.valid && POINTER_MODE_SELECT |-> REQ_REJECT)
      else $error("taken outside dsp mode");
   chk_k16_refuse: assert property (REQ.valid && REQ.op == 3'h5 && (REQ.parallel || REQ.space == 2'h3) |-> REQ_REJECT)
      else $error("bad immediate taken");
   chk_refuse_quiet: assert property (REQ.valid && REQ_REJECT |=> !ACC.valid)
      else $error("refused op issued");
   chk_issue_space: assert property (REQ.valid && !REQ_REJECT |=> ACC.valid && ACC.space == $past(REQ.space))
      else $error("issue missing");
   chk_post_addr: assert property (ok && REQ.op inside {3'h2, 3'h3} |=> ACC.addr == p_r)
      else $error("post op address");
   chk_t1_add: assert property (ok && REQ.op == 3'h2 |=> nw == p_r + t_r)
      else $error("post add pointer");
   chk_t1_sub: assert property (ok && REQ.op == 3'h3 |=> nw == p_r - t_r)
      else $error("post subtract pointer");
   chk_t1_index: assert property (ok && REQ.op == 3'h4 |=> ACC.addr == p_r + t_r && nw == p_r)
      else $error("temp index");
   chk_k16_index: assert property (ok && REQ.op == 3'h5 |=> ACC.addr == p_r + k_r && nw == p_r)
      else $error("immediate index");
   cover property (ok && REQ.op == 3'h0);
   cover property (ok && REQ.op == 3'h5);
   cover property (REQ.valid && REQ_REJECT);
endmodule
bind aiag_top aiag_top_checker #(.NP(NP)) chk (.REF_CLK, .RSTN, .REQ, .POINTER_MODE_SELECT,
   .TEMP_REGISTER_ONE, .PTR_LOAD, .ACC, .REQ_REJECT, .EXTENDED_AUX_POINTER_N);
`default_nettype wire

// >>> dv/aiag_top_test.sv
// bench: operand table, then compat, circular, back-to-back, refusals
// assumes the decoder model feeds pointer 3
`timescale 1ns/1ps
`default_nettype none
module aiag_top_test;
   typedef struct packed {
      logic [2:0] op;
      logic [22:0] p;
      logic [15:0] t;
      logic [22:0] a;
      logic [22:0] n;
   } aiag_row_t;
   logic clk = 1'h0, rstn = 1'h0, v = 1'h0, par = 1'h0, pms = 1'h0, cm = 1'h0, ld = 1'h0;
   logic [2:0] op = 3'h0, ls = 3'h0;
   logic [1:0] sp = 2'h0;
   logic [15:0] t = 16'h0;
   logic [7:0] circ = 8'h0;
   logic [127:0] base = 128'h0;
   logic [22:0] lv = 23'h0;
   logic [183:0] xp;
   logic rej;
   aiag_pkg::aiag_req_t req;
   aiag_pkg::aiag_acc_t acc;
   int n_errors = 0;
   int checks = 0;
   // reverse-carry rows flip under ordinary carries
   aiag_row_t rows [6] = '{'{3'h2, 23'h100, 16'hFFFF, 23'h100, 23'hFF}, '{3'h3, 23'h0, 16'h1, 23'h0, 23'h7FFFFF},
      '{3'h5, 23'h10, 16'h8000, 23'h7F8010, 23'h10}, '{3'h4, 23'h7FFFFF, 16'h2, 23'h1, 23'h7FFFFF},
      '{3'h0, 23'h4, 16'h4, 23'h4, 23'h2}, '{3'h1, 23'h2, 16'h4, 23'h2, 23'h4}};
   aiag_dec_model dec (.v(v), .op(op), .sp(sp), .par(par), .ext(t), .req(req));
   aiag_top uut (.REF_CLK(clk), .RSTN(rstn), .REQ(req), .POINTER_MODE_SELECT(pms), .COMPATIBILITY_MODE_BIT(cm),
      .TEMP_REGISTER_ZERO(t), .TEMP_REGISTER_ONE(t), .CIRC_ENABLE(circ), .BUFFER_START_BASE(base), .PTR_LOAD(ld),
      .PTR_LOAD_SEL(ls), .PTR_LOAD_VAL(lv), .ACC(acc), .REQ_REJECT(rej), .EXTENDED_AUX_POINTER_N(xp));
   initial forever #25 clk = ~clk;
   task automatic chk(string s, logic [23:0] g, logic [23:0] e);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic load(logic [2:0] k, logic [22:0] x);
      @(negedge clk);
      ld = 1'h1;
      ls = k;
      lv = x;
      @(negedge clk);
      ld = 1'h0;
   endtask
   // one request; returns where its address stands
   task automatic issue(logic [2:0] o, logic [15:0] x);
      @(negedge clk);
      v = 1'h1;
      op = o;
      t = x;
      @(negedge clk);
      v = 1'h0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      tally_and_finish;
   end
   initial begin
      repeat (8) @(negedge clk);
      rstn = 1'h1;
      chk("reset ptr", xp[91:69], 23'h0);
      foreach (rows[i]) begin
         sp = i[1:0];
         load(3'h3, rows[i].p);
         issue(rows[i].op, rows[i].t);
         chk("addr", acc.addr, rows[i].a);
         chk("ptr", xp[91:69], rows[i].n);
         chk("space", {acc.valid, acc.space}, {1'h1, sp});
         $display("row %0d done", i);
      end
      sp = 2'h0;
      load(3'h0, 23'h4);
      cm = 1'h1;
      load(3'h3, 23'h4);
      issue(3'h0, 16'h1);
      chk("compat", xp[91:69], 23'h2);
      cm = 1'h0;
      circ = 8'h08;
      base[63:48] = 16'h0100;
      issue(3'h0, 16'h4);
      chk("circ addr", acc.addr, 23'h102);
      chk("circ ptr", xp[91:69], 23'h2);
      circ = 8'h0;
      // second request must see the first one's update
      @(negedge clk);
      v = 1'h1;
      op = 3'h2;
      t = 16'h3;
      @(negedge clk);
      chk("first of pair", acc.addr, 23'h2);
      @(negedge clk);
      v = 1'h0;
      chk("back to back", acc.addr, 23'h5);
      for (int k = 0; k < 3; k++) begin
         pms = (k == 0);
         par = (k == 1);
         sp = (k == 2) ? 2'h3 : 2'h0;
         issue(k ? 3'h5 : 3'h2, 16'h1);
         chk("refused", {acc.valid, xp[91:69]}, 24'h8);
      end
      $display("corner tests done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
